// ---- verilog/adcss_pkg.sv ----
package adcss_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_CTRL0    = 8'h00;
  localparam logic [7:0] OFS_CTRL1    = 8'h04;
  localparam logic [7:0] OFS_INSEL    = 8'h08;
  localparam logic [7:0] OFS_MODE     = 8'h0c;
  localparam logic [7:0] OFS_IRQ      = 8'h10;
  localparam logic [2:0] RES_PAGE     = 3'h1;

  // Field positions inside the registers.
  localparam int unsigned START_BIT  = 0;
  localparam int unsigned STBY_BIT   = 0;
  localparam int unsigned RES8_BIT   = 1;
  localparam int unsigned SIZE_LSB   = 0;
  localparam int unsigned GROUP_LSB  = 2;
  localparam int unsigned REPEAT_BIT = 0;
  localparam int unsigned TRIG_LSB   = 1;
  localparam int unsigned IRQ_BIT    = 0;

  // Reset values.
  localparam logic       START_RST  = 1'b0;
  localparam logic       STBY_RST   = 1'b0;
  localparam logic       RES8_RST   = 1'b0;
  localparam logic [1:0] SIZE_RST   = 2'h0;
  localparam logic [1:0] GROUP_RST  = 2'h0;
  localparam logic       REPEAT_RST = 1'b0;
  localparam logic [1:0] TRIG_RST   = 2'h0;
  localparam logic       IRQ_RST    = 1'b0;

  // Sweep size, pin group and trigger source codes.
  localparam logic [1:0] SIZE_2     = 2'h0;
  localparam logic [1:0] SIZE_4     = 2'h1;
  localparam logic [1:0] SIZE_8     = 2'h3;
  localparam logic [1:0] GRP_HIGH   = 2'h1;
  localparam logic [3:0] HIGH_BASE  = 4'h8;
  localparam logic [1:0] TRIG_SW    = 2'h0;
  localparam logic [1:0] TRIG_TIMER = 2'h2;
  localparam logic [1:0] TRIG_EXT   = 2'h3;

  // One conversion request to the analog core.
  typedef struct packed {
    logic [3:0] channel;
    logic       eight_bit;
  } adcss_req_t;

  // One result on its way to a result register.
  typedef struct packed {
    logic [2:0] slot;
    logic [9:0] code;
  } adcss_res_t;

  typedef enum logic [2:0] {
    ADCSS_IDLE  = 3'b001,
    ADCSS_ISSUE = 3'b010,
    ADCSS_WAIT  = 3'b100
  } adcss_state_t;

endpackage

// ---- verilog/adcss_result_mem.sv ----
module adcss_result_mem (
  // Clock and reset.
  input  wire logic                clk,
  input  wire logic                arst_n,
  // Write port from the sequencer.
  input  wire logic                we,
  input  wire adcss_pkg::adcss_res_t wr,
  // Registered read port for the bus.
  input  wire logic [2:0]          rd_slot,
  output logic      [9:0]          rd_code
);

  logic [9:0] mem [8];

  // Storage has no reset, so contents are undefined until a conversion lands.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[wr.slot] <= wr.code;
    end
  end

  // Read data leaves through a register.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_code <= 10'h000;
    end else begin
      rd_code <= mem[rd_slot];
    end
  end

endmodule

// ---- verilog/adcss_sweep.sv ----
// Operation
// - Single sweep converts each pin of the chosen group exactly once.
// - Repeat sweep converts the group pass after pass until software stops it.
// - Ten-bit and eight-bit resolution are both offered in both sweep modes.
// - A sweep starts on software, timer event or external pin falling edge.
// - Single sweep clears the start flag itself after the last pin.
// - Repeat stops only on a zero write; single may also stop early so.
// - Each completed pass raises the interrupt flag; repeat then carries on.
// - Size and group fields pick inputs 0-1, 8-9, 0-3, 8-11, 0-5 or 0-7.
// - Result register i holds input i, or input i+8 for the high group.
// - The interrupt flag clears on acknowledge or on a software write of zero.
// - A forced stop raises no interrupt and leaves results unusable.
// - Result registers are read-only, undefined after reset.
module adcss_sweep (
  // Clock and reset.
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  // AHB-Lite slave.
  input  wire logic                   hsel,
  input  wire logic [7:0]             haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  // Trigger sources.
  input  wire logic                   pwm_timer_trigger,
  input  wire logic                   ext_conv_trigger_pin,
  // Analog converter core.
  output logic                        ana_start,
  output adcss_pkg::adcss_req_t       ana_req,
  input  wire logic                   ana_done,
  input  wire logic [9:0]             ana_data,
  // Interrupt request and acknowledge.
  output logic                        irq_request_flag,
  input  wire logic                   irq_ack
);

  adcss_pkg::adcss_state_t state;
  adcss_pkg::adcss_state_t next_state;
  logic       conv_start_flag;
  logic       conv_standby_bit;
  logic       res8;
  logic [1:0] sweep_size;
  logic [1:0] pin_group;
  logic       repeat_mode;
  logic [1:0] trig_src;
  logic [2:0] idx;
  logic [2:0] next_idx;
  logic       dp_valid;
  logic       dp_write;
  logic [7:0] dp_addr;
  logic [31:0] rd_q;
  logic       ext_s1;
  logic       ext_s2;
  logic       ext_s3;
  logic       ext_level;
  logic [9:0] mem_code;
  adcss_pkg::adcss_res_t mem_wr;

  // Bus decode and write strobes for the data phase.
  wire        accept    = hsel & htrans[1] & hready;
  wire        wr        = dp_valid & dp_write;
  wire        wr_ctrl0  = wr & (dp_addr == adcss_pkg::OFS_CTRL0);
  wire        wr_ctrl1  = wr & (dp_addr == adcss_pkg::OFS_CTRL1);
  wire        wr_insel  = wr & (dp_addr == adcss_pkg::OFS_INSEL);
  wire        wr_mode   = wr & (dp_addr == adcss_pkg::OFS_MODE);
  wire        wr_irq    = wr & (dp_addr == adcss_pkg::OFS_IRQ);
  wire        rd_is_res = (dp_addr[7:5] == adcss_pkg::RES_PAGE);

  // A zero written to the start flag aborts whatever is in flight.
  wire        stop_req  = wr_ctrl0 & ~hwdata[adcss_pkg::START_BIT];

  // Falling edge of the external trigger once the synchroniser has settled.
  wire        ext_agree = (ext_s2 == ext_s3);
  wire        ext_fall  = ext_agree & ~ext_s3 & ext_level;

  // Trigger selection; software trigger fires as soon as the flag is set.
  wire        trig_hit  = (trig_src == adcss_pkg::TRIG_SW)    ? 1'b1 :
                          (trig_src == adcss_pkg::TRIG_TIMER) ? pwm_timer_trigger :
                          (trig_src == adcss_pkg::TRIG_EXT)   ? ext_fall : 1'b0;
  wire        go        = conv_start_flag & conv_standby_bit & trig_hit & ~stop_req;

  // Last index of the group and whether the high bank is in use.
  wire [2:0]  last_idx  = {sweep_size, 1'b1};
  wire        high_grp  = (pin_group == adcss_pkg::GRP_HIGH) & (sweep_size <= adcss_pkg::SIZE_4);
  wire        in_wait   = (state == adcss_pkg::ADCSS_WAIT);
  wire        done_ok   = in_wait & ana_done & ~stop_req;
  wire        sweep_end = done_ok & (idx == last_idx);

  // Results land in the register of the same low index, pass after pass.
  assign mem_wr.slot = idx;
  assign mem_wr.code = res8 ? {2'b00, ana_data[7:0]} : ana_data;

  // Converted channel for a given sweep position.
  function automatic logic [3:0] chan_of(input logic [2:0] i, input logic hi);
    chan_of = hi ? (adcss_pkg::HIGH_BASE | {1'b0, i}) : {1'b0, i};
  endfunction

  // Sequencer next-state logic: ascending channels, restart or finish at the end.
  always_comb begin
    next_state = state;
    next_idx   = idx;
    case (state)
      adcss_pkg::ADCSS_IDLE: begin
        next_idx = 3'h0;
        if (go) begin
          next_state = adcss_pkg::ADCSS_ISSUE;
        end
      end
      adcss_pkg::ADCSS_ISSUE: begin
        if (stop_req) begin
          next_state = adcss_pkg::ADCSS_IDLE;
        end else begin
          next_state = adcss_pkg::ADCSS_WAIT;
        end
      end
      adcss_pkg::ADCSS_WAIT: begin
        if (stop_req) begin
          next_state = adcss_pkg::ADCSS_IDLE;
        end else if (sweep_end && repeat_mode) begin
          next_state = adcss_pkg::ADCSS_ISSUE;
          next_idx   = 3'h0;
        end else if (sweep_end) begin
          next_state = adcss_pkg::ADCSS_IDLE;
        end else if (ana_done) begin
          next_state = adcss_pkg::ADCSS_ISSUE;
          next_idx   = idx + 3'h1;
        end
      end
      default: begin
        next_state = adcss_pkg::ADCSS_IDLE;
        next_idx   = 3'h0;
      end
    endcase
  end

  // Sequencer state, index and the request held toward the analog core.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state   <= adcss_pkg::ADCSS_IDLE;
      idx     <= 3'h0;
      ana_req <= '0;
    end else begin
      state           <= next_state;
      idx             <= next_idx;
      ana_req.channel <= chan_of(next_idx, high_grp);
      ana_req.eight_bit <= res8;
    end
  end

  // The core is started for one cycle per channel.
  assign ana_start = (state == adcss_pkg::ADCSS_ISSUE) & ~stop_req;

  // Start flag: software write wins, single sweep clears it at the end.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_start_flag <= adcss_pkg::START_RST;
    end else if (wr_ctrl0) begin
      conv_start_flag <= hwdata[adcss_pkg::START_BIT];
    end else if (sweep_end && !repeat_mode) begin
      conv_start_flag <= 1'b0;
    end
  end

  // Interrupt flag: a pass end wins over an acknowledge or a clearing write.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_request_flag <= adcss_pkg::IRQ_RST;
    end else if (sweep_end) begin
      irq_request_flag <= 1'b1;
    end else if (irq_ack || (wr_irq && !hwdata[adcss_pkg::IRQ_BIT])) begin
      irq_request_flag <= 1'b0;
    end
  end

  // Configuration registers.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_standby_bit <= adcss_pkg::STBY_RST;
      res8             <= adcss_pkg::RES8_RST;
      sweep_size       <= adcss_pkg::SIZE_RST;
      pin_group        <= adcss_pkg::GROUP_RST;
      repeat_mode      <= adcss_pkg::REPEAT_RST;
      trig_src         <= adcss_pkg::TRIG_RST;
    end else begin
      if (wr_ctrl1) begin
        conv_standby_bit <= hwdata[adcss_pkg::STBY_BIT];
        res8             <= hwdata[adcss_pkg::RES8_BIT];
      end
      if (wr_insel) begin
        sweep_size <= hwdata[adcss_pkg::SIZE_LSB +: 2];
        pin_group  <= hwdata[adcss_pkg::GROUP_LSB +: 2];
      end
      if (wr_mode) begin
        repeat_mode <= hwdata[adcss_pkg::REPEAT_BIT];
        trig_src    <= hwdata[adcss_pkg::TRIG_LSB +: 2];
      end
    end
  end

  // Three-stage synchroniser and settled level of the external trigger pin.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_s1    <= 1'b1;
      ext_s2    <= 1'b1;
      ext_s3    <= 1'b1;
      ext_level <= 1'b1;
    end else begin
      ext_s1 <= ext_conv_trigger_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      if (ext_agree) begin
        ext_level <= ext_s3;
      end
    end
  end

  // Address phase capture and register read data.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
      rd_q     <= 32'h0000_0000;
    end else if (hready) begin
      dp_valid <= accept;
      dp_write <= hwrite;
      dp_addr  <= haddr;
      case (haddr)
        adcss_pkg::OFS_CTRL0: rd_q <= {31'h0, conv_start_flag};
        adcss_pkg::OFS_CTRL1: rd_q <= {30'h0, res8, conv_standby_bit};
        adcss_pkg::OFS_INSEL: rd_q <= {28'h0, pin_group, sweep_size};
        adcss_pkg::OFS_MODE:  rd_q <= {29'h0, trig_src, repeat_mode};
        adcss_pkg::OFS_IRQ:   rd_q <= {31'h0, irq_request_flag};
        default:              rd_q <= 32'h0000_0000;
      endcase
    end
  end

  // Result registers; only the sequencer writes them, bus writes are dropped.
  adcss_result_mem u_mem (
    .clk     (clk),
    .arst_n  (arst_n),
    .we      (done_ok),
    .wr      (mem_wr),
    .rd_slot (haddr[4:2]),
    .rd_code (mem_code)
  );

  // Zero wait state, always OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rd_is_res ? {22'h0, mem_code} : rd_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_group_range;
    ana_start |-> (ana_req.channel[2:0] <= last_idx) && (ana_req.channel[3] == high_grp);
  endproperty
  a_group_range: assert property (p_group_range) else $error("channel outside group");

  property p_single_clear;
    (sweep_end && !repeat_mode && !wr_ctrl0) |=> !conv_start_flag;
  endproperty
  a_single_clear: assert property (p_single_clear) else $error("start flag not cleared");

  property p_irq_set;
    sweep_end |=> irq_request_flag;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("pass end without interrupt");

  property p_stop_quiet;
    (stop_req && state != adcss_pkg::ADCSS_IDLE) |=> (state == adcss_pkg::ADCSS_IDLE) && !$rose(irq_request_flag);
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("forced stop misbehaved");

  property p_repeat_restart;
    (sweep_end && repeat_mode) |=> (state == adcss_pkg::ADCSS_ISSUE) && (idx == 3'h0) &&
                                   (ana_start || stop_req);
  endproperty
  a_repeat_restart: assert property (p_repeat_restart) else $error("repeat sweep did not restart");

  property p_slot_match;
    done_ok |-> (mem_wr.slot == ana_req.channel[2:0]);
  endproperty
  a_slot_match: assert property (p_slot_match) else $error("result in wrong register");

  property p_trig_start;
    (state == adcss_pkg::ADCSS_IDLE) ##1 (state == adcss_pkg::ADCSS_ISSUE) |-> $past(trig_hit && conv_start_flag);
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("sweep started without trigger");

  property p_res_mode;
    ana_start |-> (ana_req.eight_bit == res8);
  endproperty
  a_res_mode: assert property (p_res_mode) else $error("resolution mismatch");

  property p_flag_busy;
    (state != adcss_pkg::ADCSS_IDLE) |-> conv_start_flag;
  endproperty
  a_flag_busy: assert property (p_flag_busy) else $error("start flag low while busy");

  property p_irq_clear;
    (irq_ack && !sweep_end) |=> !irq_request_flag;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("interrupt flag not cleared");

  property p_ascend;
    (done_ok && idx != last_idx) |=> (idx == $past(idx) + 3'h1) && (ana_start || stop_req);
  endproperty
  a_ascend: assert property (p_ascend) else $error("channels not ascending");

endmodule

// ---- tb/adcss_analog_src.sv ----
module adcss_analog_src (
  // Clock.
  input  wire logic                  clk,
  // Converter core side.
  input  wire logic                  ana_start,
  input  wire adcss_pkg::adcss_req_t ana_req,
  output logic                       ana_done,
  output logic      [9:0]            ana_data,
  // Bench controls: code stamp and slow answers.
  input  wire logic [5:0]            stamp,
  input  wire logic                  slow
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       busy;
  logic [3:0] wait_cnt;
  logic [9:0] last;

  initial begin
    ana_done = 1'b0;
    ana_data = 10'h000;
    busy     = 1'b0;
    wait_cnt = 4'h0;
    last     = 10'h000;
  end

  // Converts after a short or long delay; the code carries the channel and a stamp.
  // Outside the done pulse the data lines show the inverse of the last code, so stale reads are caught.
  always @(posedge clk) begin
    ana_done <= 1'b0;
    ana_data <= ~last;
    if (ana_start === 1'b1) begin
      busy     <= 1'b1;
      wait_cnt <= slow ? 4'h9 : 4'h1;
    end else if (busy) begin
      if (wait_cnt == 4'h0) begin
        busy     <= 1'b0;
        ana_done <= 1'b1;
        // An eight-bit result has junk above bit 7, so the design must drop it.
        ana_data <= ana_req.eight_bit ? {2'b11, ana_req.channel[1:0], stamp} : {ana_req.channel, stamp};
        last     <= {ana_req.channel, stamp};
      end else begin
        wait_cnt <= wait_cnt - 4'h1;
      end
    end
  end
endmodule

// ---- tb/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clk;
  logic                  arst_n;
  logic                  hsel;
  logic [7:0]            haddr;
  logic [1:0]            htrans;
  logic                  hwrite;
  logic [31:0]           hwdata;
  logic [31:0]           hrdata;
  logic                  hreadyout;
  logic                  hresp;
  logic                  pwm_timer_trigger;
  logic                  ext_conv_trigger_pin;
  logic                  ana_start;
  adcss_pkg::adcss_req_t ana_req;
  logic                  ana_done;
  logic [9:0]            ana_data;
  logic                  irq_request_flag;
  logic                  irq_ack;
  logic [5:0]            stamp;
  logic                  slow;
  logic [3:0]            base;
  logic [31:0]           rd;
  int                    fail_count;
  int                    comparisons;
  int                    starts;
  int                    grp_pins;
  int                    k;

  adcss_sweep u_dut (
    .clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pwm_timer_trigger(pwm_timer_trigger), .ext_conv_trigger_pin(ext_conv_trigger_pin),
    .ana_start(ana_start), .ana_req(ana_req), .ana_done(ana_done), .ana_data(ana_data),
    .irq_request_flag(irq_request_flag), .irq_ack(irq_ack)
  );

  adcss_analog_src u_src (
    .clk(clk), .ana_start(ana_start), .ana_req(ana_req), .ana_done(ana_done), .ana_data(ana_data),
    .stamp(stamp), .slow(slow)
  );

  // The clock runs at 125 MHz and never stops or changes rate, not even mid-conversion.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Counts conversion requests and checks that channels rise from the group base, pass after pass.
  always @(posedge clk) begin
    if (ana_start === 1'b1) begin
      check("channel", 32'(ana_req.channel), 32'(base) + 32'(starts % grp_pins));
      starts <= starts + 1;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    if (fail_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Waits for hready high at a rising edge and takes the read data that stands at that same edge.
  task automatic wait_ready(output logic [31:0] data);
    logic r;
    int   n;
    n = 0;
    do begin
      @(posedge clk);
      r    = hreadyout;
      data = hrdata;
      n++;
    end while (r !== 1'b1 && n < 50);
    if (r !== 1'b1) begin
      fail_count++;
      tally_and_finish();
    end
  endtask

  // One single AHB-Lite word transfer: address phase, then data phase.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] data);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    wait_ready(data);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready(data);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    check(what, d, exp);
  endtask

  // Polls the start flag until the sweep has ended.
  task automatic wait_stop();
    int n;
    n = 0;
    do begin
      bus(1'b0, adcss_pkg::OFS_CTRL0, 32'h0, rd);
      n++;
    end while (rd[0] !== 1'b0 && n < 300);
    if (rd[0] !== 1'b0) begin
      fail_count++;
      tally_and_finish();
    end
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq_request_flag !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    if (irq_request_flag !== 1'b1) begin
      fail_count++;
      tally_and_finish();
    end
  endtask

  // Runs one software-triggered single sweep and checks every result of the group.
  task automatic sweep(input logic [1:0] sz, input logic [1:0] grp, input int npins, input logic r8);
    int         i;
    logic [9:0] e;
    base     = (grp == adcss_pkg::GRP_HIGH) ? adcss_pkg::HIGH_BASE : 4'h0;
    starts   = 0;
    grp_pins = npins;
    wr(adcss_pkg::OFS_CTRL1, {30'h0, r8, 1'b1});
    wr(adcss_pkg::OFS_INSEL, {28'h0, grp, sz});
    wr(adcss_pkg::OFS_MODE, 32'h0);
    cycles(1);
    wr(adcss_pkg::OFS_CTRL0, 32'h1);
    cycles(1);
    rdchk("start flag while running", adcss_pkg::OFS_CTRL0, 32'h1);
    wait_stop();
    check("conversions per sweep", 32'(starts), 32'(npins));
    check("irq after sweep", 32'(irq_request_flag), 32'h1);
    for (i = 0; i < npins; i++) begin
      e = {base + i[3:0], stamp};
      if (r8) e = {2'b00, e[7:0]};
      rdchk("result", 8'h20 + 8'(4 * i), {22'h0, e});
    end
    wr(adcss_pkg::OFS_IRQ, 32'h0);
    rdchk("irq reg cleared", adcss_pkg::OFS_IRQ, 32'h0);
  endtask

  // Main sequence: reset, single sweeps over every group, triggers, repeat sweep and forced stops.
  initial begin
    arst_n = 1'b0; hsel = 1'b0; haddr = 8'h00; htrans = 2'h0; hwrite = 1'b0; hwdata = 32'h0;
    pwm_timer_trigger = 1'b0; ext_conv_trigger_pin = 1'b1; irq_ack = 1'b0; stamp = 6'h2a; slow = 1'b1;
    base = 4'h0; fail_count = 0; comparisons = 0; starts = 0; grp_pins = 2;
    cycles(12);
    arst_n <= 1'b1;
    cycles(1);
    for (k = 0; k < 6; k++) rdchk("reset or unmapped", 8'(4 * k), 32'h0);
    sweep(2'h0, 2'h0, 2, 1'b0);
    sweep(2'h0, 2'h1, 2, 1'b0);
    sweep(2'h1, 2'h0, 4, 1'b0);
    sweep(2'h1, 2'h1, 4, 1'b0);
    sweep(2'h2, 2'h0, 6, 1'b0);
    sweep(2'h3, 2'h0, 8, 1'b0);
    stamp = 6'h15;
    sweep(2'h0, 2'h1, 2, 1'b1);
    wr(8'h20, 32'h3ff);
    check("okay on dropped write", 32'(hresp), 32'h0);
    rdchk("result write ignored", 8'h20, 32'h15);
    // Timer trigger, answered promptly.
    slow = 1'b0; base = 4'h0; starts = 0;
    wr(adcss_pkg::OFS_INSEL, 32'h0);
    wr(adcss_pkg::OFS_MODE, {29'h0, adcss_pkg::TRIG_TIMER, 1'b0});
    wr(adcss_pkg::OFS_CTRL0, 32'h1);
    cycles(10);
    check("armed without trigger", 32'(starts), 32'h0);
    pwm_timer_trigger <= 1'b1;
    cycles(1);
    pwm_timer_trigger <= 1'b0;
    wait_stop();
    check("timer sweep", 32'(starts), 32'h2);
    wr(adcss_pkg::OFS_IRQ, 32'h0);
    // External pin falling edge, then acknowledge clears the request.
    starts = 0;
    wr(adcss_pkg::OFS_MODE, {29'h0, adcss_pkg::TRIG_EXT, 1'b0});
    wr(adcss_pkg::OFS_CTRL0, 32'h1);
    ext_conv_trigger_pin <= 1'b0;
    wait_stop();
    check("pin sweep", 32'(starts), 32'h2);
    ext_conv_trigger_pin <= 1'b1;
    irq_ack <= 1'b1;
    cycles(1);
    irq_ack <= 1'b0;
    cycles(1);
    check("ack clears irq", 32'(irq_request_flag), 32'h0);
    // Repeat sweep keeps going after each pass and overwrites the results.
    slow = 1'b1; starts = 0;
    wr(adcss_pkg::OFS_MODE, 32'h1);
    wr(adcss_pkg::OFS_CTRL0, 32'h1);
    wait_irq();
    stamp = 6'h33;
    rdchk("repeat still running", adcss_pkg::OFS_CTRL0, 32'h1);
    irq_ack <= 1'b1;
    cycles(1);
    irq_ack <= 1'b0;
    cycles(1);
    wait_irq();
    check("second pass ran", 32'(starts >= 4), 32'h1);
    rdchk("repeat result 0", 8'h20, {22'h0, 4'h0, 6'h33});
    rdchk("repeat result 1", 8'h24, {22'h0, 4'h1, 6'h33});
    wr(adcss_pkg::OFS_IRQ, 32'h0);
    wr(adcss_pkg::OFS_CTRL0, 32'h0);
    cycles(2);
    starts = 0;
    cycles(40);
    check("repeat stopped", 32'(starts), 32'h0);
    check("no irq after stop", 32'(irq_request_flag), 32'h0);
    // Single sweep of eight pins stopped early by software.
    wr(adcss_pkg::OFS_INSEL, 32'h3);
    wr(adcss_pkg::OFS_MODE, 32'h0);
    starts = 0; grp_pins = 8;
    wr(adcss_pkg::OFS_CTRL0, 32'h1);
    cycles(15);
    wr(adcss_pkg::OFS_CTRL0, 32'h0);
    cycles(100);
    check("forced stop irq", 32'(irq_request_flag), 32'h0);
    check("stopped early", 32'(starts < 8), 32'h1);
    rdchk("flag after stop", adcss_pkg::OFS_CTRL0, 32'h0);
    tally_and_finish();
  end
endmodule
